// ### common/pfc_cfg.svh
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
`define PFC_NGRP 13
`define PFC_NPIN 8
`define PFC_ROUTE_BASE 12'h000
`define PFC_ALT_OFS 12'h004
`define PFC_GRP_STRIDE 12'h008
`define PFC_CLK_OFS 12'h100
`define PFC_SUM_OFS 12'h104
`define PFC_ROUTE_RST 8'h00
`define PFC_ALT_RST 16'h0000
`define PFC_RUN_BIT 8
`define PFC_DIV_HI 7
`define PFC_DIV_LO 4
`define PFC_KEY_HI 3
`define PFC_KEY_LO 2
`define PFC_SRC_HI 1
`define PFC_SRC_LO 0
`define PFC_SRC_IMPL 4'hb
`define PFC_IRQ_GRP 13'h00ff
`endif

// ### common/pfc_pkg.sv
`default_nettype none
package pfc_pkg;
  typedef enum logic [1:0] {
    PFC_SRC_INTERNAL = 2'h0,
    PFC_SRC_LOW_SPEED = 2'h1,
    PFC_SRC_HIGH_SPEED = 2'h2,
    PFC_SRC_EXTERNAL = 2'h3
  } pfc_src_t;
  typedef enum logic [1:0] {
    PFC_KEY_OFF = 2'h0,
    PFC_KEY_PINS2 = 2'h1,
    PFC_KEY_PINS3 = 2'h2,
    PFC_KEY_PINS4 = 2'h3
  } pfc_key_t;
endpackage : pfc_pkg
`default_nettype wire

// ### hw/pfc_top.sv
// Chosen here: the address-and-strobe port and the register offsets.
`include "pfc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pfc_top
  import pfc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [11:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  input wire logic wp_unlocked,
  input wire logic debug_mode,
  input wire logic [3:0] src_tick,
  input wire logic [3:0] grp0_in,
  input wire logic [103:0] pin_event_flag,
  input wire logic [103:0] pin_event_enable,
  output logic [103:0] pin_route_to_peripheral,
  output logic [207:0] pin_alt_choice,
  output logic sample_tick,
  output logic port_clk_run,
  output logic key_combo_reset
);
  localparam logic [3:0] SRC_IMPL = `PFC_SRC_IMPL;
  localparam logic [12:0] IRQ_GRP = `PFC_IRQ_GRP;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction : addr_is

  // Per-group reset value hook; all groups use the common value for now
  function automatic logic [15:0] alt_reset(input int g);
    return `PFC_ALT_RST;
  endfunction : alt_reset

  logic [7:0] route_q [`PFC_NGRP];
  logic [15:0] alt_q [`PFC_NGRP];
  logic run_while_halted_q;
  logic [3:0] sample_clock_ratio_q;
  pfc_key_t key_combo_reset_cfg_q;
  pfc_src_t sample_clock_origin_q;
  logic [12:0] group_pending_q;
  logic [12:0] group_pending_d;
  logic [14:0] div_cnt_q;
  logic [14:0] div_limit;
  logic tick_in;
  logic clk_wr;
  logic clk_wr_ok;
  logic [15:0] rdata_d;
  logic key_hit;
  logic [15:0] clk_view;

  genvar g, p;
  generate
    for (g = 0; g < `PFC_NGRP; g++) begin : g_grp
      localparam logic [11:0] ROUTE_A = `PFC_ROUTE_BASE + 12'(g) * `PFC_GRP_STRIDE;
      localparam logic [11:0] ALT_A = ROUTE_A + `PFC_ALT_OFS;
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          route_q[g] <= `PFC_ROUTE_RST;
        end else if (bus_wr && addr_is(bus_addr, ROUTE_A)) begin
          route_q[g] <= bus_wdata[7:0];
        end
      end
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          alt_q[g] <= alt_reset(g);
        end else if (bus_wr && addr_is(bus_addr, ALT_A)) begin
          alt_q[g] <= bus_wdata;
        end
      end
      for (p = 0; p < `PFC_NPIN; p++) begin : g_pin
        assign pin_route_to_peripheral[g*8+p] = route_q[g][p];
        // Gated so a stale choice never leaks onto a GPIO pin
        assign pin_alt_choice[g*16+2*p +: 2] =
          route_q[g][p] ? alt_q[g][2*p +: 2] : 2'h0;
      end
      // Derived live, so clearing the pin flag clears the bit with no write path
      assign group_pending_d[g] = IRQ_GRP[g] &&
        (|(pin_event_flag[g*8 +: 8] & pin_event_enable[g*8 +: 8]));
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      group_pending_q <= 13'h0000;
    end else begin
      group_pending_q <= group_pending_d;
    end
  end

  assign clk_wr = bus_wr && addr_is(bus_addr, `PFC_CLK_OFS);
  assign clk_wr_ok = clk_wr && wp_unlocked;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      run_while_halted_q <= 1'b0;
      sample_clock_ratio_q <= 4'h0;
      key_combo_reset_cfg_q <= PFC_KEY_OFF;
    end else if (clk_wr_ok) begin
      run_while_halted_q <= bus_wdata[`PFC_RUN_BIT];
      sample_clock_ratio_q <= bus_wdata[`PFC_DIV_HI:`PFC_DIV_LO];
      key_combo_reset_cfg_q <= pfc_key_t'(bus_wdata[`PFC_KEY_HI:`PFC_KEY_LO]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sample_clock_origin_q <= PFC_SRC_INTERNAL;
    end else if (clk_wr_ok && SRC_IMPL[bus_wdata[`PFC_SRC_HI:`PFC_SRC_LO]]) begin
      // Unimplemented codes leave the old source in place
      sample_clock_origin_q <= pfc_src_t'(bus_wdata[`PFC_SRC_HI:`PFC_SRC_LO]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      port_clk_run <= 1'b1;
    end else begin
      port_clk_run <= !debug_mode || run_while_halted_q;
    end
  end

  assign tick_in = src_tick[sample_clock_origin_q] && port_clk_run;
  assign div_limit = 15'((16'h0001 << sample_clock_ratio_q) - 16'h0001);

  // Counter restarts on a config write so a new ratio starts from a clean phase
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_cnt_q <= 15'h0000;
      sample_tick <= 1'b0;
    end else if (clk_wr_ok) begin
      div_cnt_q <= 15'h0000;
      sample_tick <= 1'b0;
    end else if (tick_in && div_cnt_q >= div_limit) begin
      div_cnt_q <= 15'h0000;
      sample_tick <= 1'b1;
    end else begin
      div_cnt_q <= tick_in ? div_cnt_q + 15'h0001 : div_cnt_q;
      sample_tick <= 1'b0;
    end
  end

  always_comb begin
    unique case (key_combo_reset_cfg_q)
      PFC_KEY_OFF: key_hit = 1'b0;
      PFC_KEY_PINS2: key_hit = ~|grp0_in[1:0];
      PFC_KEY_PINS3: key_hit = ~|grp0_in[2:0];
      PFC_KEY_PINS4: key_hit = ~|grp0_in[3:0];
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      key_combo_reset <= 1'b0;
    end else begin
      key_combo_reset <= key_hit;
    end
  end

  assign clk_view = {7'h00, run_while_halted_q, sample_clock_ratio_q,
                     key_combo_reset_cfg_q, sample_clock_origin_q};

  always_comb begin
    rdata_d = 16'h0000;
    for (int i = 0; i < `PFC_NGRP; i++) begin
      if (addr_is(bus_addr, `PFC_ROUTE_BASE + 12'(i) * `PFC_GRP_STRIDE)) begin
        rdata_d = {8'h00, route_q[i]};
      end
      if (addr_is(bus_addr, `PFC_ROUTE_BASE + 12'(i) * `PFC_GRP_STRIDE + `PFC_ALT_OFS)) begin
        rdata_d = alt_q[i];
      end
    end
    if (addr_is(bus_addr, `PFC_CLK_OFS)) begin
      rdata_d = clk_view;
    end
    if (addr_is(bus_addr, `PFC_SUM_OFS)) begin
      rdata_d = {3'h0, group_pending_q};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bus_rdata <= 16'h0000;
    end else begin
      bus_rdata <= bus_rd ? rdata_d : 16'h0000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_ROUTE_WRITE: assert property (
    bus_wr && bus_addr == `PFC_ROUTE_BASE |=>
      pin_route_to_peripheral[7:0] == $past(bus_wdata[7:0]))
    else $error("route write not applied");

  AST_ALT_APPLIED: assert property (
    bus_wr && bus_addr == `PFC_ALT_OFS && route_q[0] == 8'hff |=>
      pin_alt_choice[15:0] == $past(bus_wdata))
    else $error("alt choice not applied");

  AST_ALT_GATED: assert property (
    !pin_route_to_peripheral[3] |-> pin_alt_choice[7:6] == 2'h0)
    else $error("alt choice leaks on GPIO pin");

  AST_DEBUG_STOP: assert property (
    debug_mode && !run_while_halted_q ##1 debug_mode |-> !port_clk_run)
    else $error("clock runs in debug mode");

  AST_DIV_ONE: assert property (
    sample_clock_ratio_q == 4'h0 && tick_in && !clk_wr_ok |=> sample_tick)
    else $error("ratio 1 missed a tick");

  AST_DIV_TWO: assert property (
    sample_tick && sample_clock_ratio_q == 4'h1 |=> !sample_tick)
    else $error("ratio 2 ticked twice in a row");

  AST_KEY_FIRE: assert property (
    key_combo_reset_cfg_q == PFC_KEY_PINS4 && grp0_in == 4'h0 |=> key_combo_reset)
    else $error("key reset missed");

  AST_KEY_OFF: assert property (
    key_combo_reset_cfg_q == PFC_KEY_OFF |=> !key_combo_reset)
    else $error("key reset while disabled");

  AST_SRC_LEGAL: assert property (
    SRC_IMPL[sample_clock_origin_q])
    else $error("unimplemented source selected");

  AST_SUM_SET: assert property (
    |(pin_event_flag[7:0] & pin_event_enable[7:0]) |=> group_pending_q[0])
    else $error("summary bit not set");

  AST_SUM_MASKED: assert property (
    pin_event_enable[7:0] == 8'h00 |=> !group_pending_q[0])
    else $error("summary set by disabled pin");

  AST_SUM_NOWRITE: assert property (
    bus_wr && bus_addr == `PFC_SUM_OFS && |(pin_event_flag[7:0] & pin_event_enable[7:0])
      ##1 |(pin_event_flag[7:0] & pin_event_enable[7:0]) |-> group_pending_q[0])
    else $error("summary cleared by write");

  AST_SUM_HIGH: assert property (
    bus_rd && bus_addr == `PFC_SUM_OFS |=> bus_rdata[15:8] == 8'h00)
    else $error("summary reserved bits set");

  AST_WP_HOLD: assert property (
    clk_wr && !wp_unlocked |=> $stable(clk_view))
    else $error("protected write took effect");

  AST_CLK_RSVD: assert property (
    bus_rd && bus_addr == `PFC_CLK_OFS |=> bus_rdata[15:9] == 7'h00)
    else $error("clock reserved bits set");

  // Absent source codes must not disturb the running source
  AST_SRC_KEEP: assert property (
    clk_wr_ok && !SRC_IMPL[bus_wdata[`PFC_SRC_HI:`PFC_SRC_LO]] |=> $stable(sample_clock_origin_q))
    else $error("absent source code changed the source");

  AST_CLK_FREE: assert property (
    !debug_mode |=> port_clk_run)
    else $error("clock stopped outside debug mode");

  AST_DIV_RESTART: assert property (
    clk_wr_ok |=> !sample_tick)
    else $error("tick on the config write");

  AST_KEY_TWO: assert property (
    key_combo_reset_cfg_q == PFC_KEY_PINS2 && grp0_in[1:0] == 2'h0 |=> key_combo_reset)
    else $error("two-pin key reset missed");

  AST_KEY_MISS: assert property (
    key_combo_reset_cfg_q == PFC_KEY_PINS3 && grp0_in[2:0] != 3'h0 |=> !key_combo_reset)
    else $error("three-pin key reset with a pin high");

  AST_ROUTE_HOLD: assert property (
    !bus_wr |=> $stable(pin_route_to_peripheral))
    else $error("route changed without a write");

  AST_SUM_CLEAR: assert property (
    !(|(pin_event_flag[7:0] & pin_event_enable[7:0])) |=> !group_pending_q[0])
    else $error("summary bit stuck after flags cleared");

  COV_KEY_RESET: cover property (key_combo_reset);
  COV_SLOW_TICK: cover property (sample_tick && sample_clock_ratio_q == 4'hf);
  COV_SUM_READ: cover property (bus_rd && bus_addr == `PFC_SUM_OFS ##1 bus_rdata[0]);
  COV_WP_BLOCK: cover property (clk_wr && !wp_unlocked);
endmodule : pfc_top
`default_nettype wire

// ### bench/pfc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_top_tb_top
  import pfc_pkg::*;
;
  logic mclk = 1'b0, rstn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, wp = 1'b0, dbg = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000, rdata, clk_m = 16'h0000, v, r, a, e;
  logic [3:0] tick = 4'h0, g0 = 4'hf;
  logic [103:0] flg = '0, ena = '0, route;
  logic [111:0] fr, er;
  logic [207:0] alt;
  logic [31:0] seed = 32'h0000b784;
  logic stick, crun, krst;
  int err_total = 0, checked = 0, cnt;
  always #2.5 mclk = ~mclk;
  pfc_top i_dut (.mclk(mclk), .rstn(rstn), .bus_addr(addr), .bus_wdata(wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(rdata), .wp_unlocked(wp), .debug_mode(dbg), .src_tick(tick),
    .grp0_in(g0), .pin_event_flag(flg), .pin_event_enable(ena), .pin_route_to_peripheral(route),
    .pin_alt_choice(alt), .sample_tick(stick), .port_clk_run(crun), .key_combo_reset(krst));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checked++;
    if (got !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] ad, input logic [15:0] d);
    @(posedge mclk);
    bus_wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] ad, output logic [15:0] d);
    @(posedge mclk);
    bus_rd <= 1'b1;
    addr <= ad;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Model keeps old source when the code names the absent oscillator
  task automatic wclk(input logic [15:0] d, input logic w);
    @(posedge mclk);
    wp <= w;
    wr(12'h100, d);
    if (w) clk_m = {7'h00, d[8:2], (d[1:0] == PFC_SRC_HIGH_SPEED) ? clk_m[1:0] : d[1:0]};
    rd(12'h100, v);
    chk("clk_ctrl", clk_m, v);
  endtask : wclk
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    #1 chk("clk_run_rst", 16'h0001, {15'h0000, crun});
    rd(12'h100, v);
    chk("clk_rst", 16'h0000, v);
    @(posedge mclk);
    #1 chk("rdata_idle", 16'h0000, rdata);
    for (int g = 0; g < 13; g++) begin
      rd(12'(8 * g + 4), v);
      chk("alt_rst", 16'h0000, v);
      r = rnd();
      a = rnd();
      // Group 0 fully routed so its choice write reaches the pins
      if (g == 0) r[7:0] = 8'hff;
      wr(12'(8 * g), r);
      wr(12'(8 * g + 4), a);
      @(posedge mclk);
      for (int p = 0; p < 8; p++) e[2*p+:2] = r[p] ? a[2*p+:2] : 2'h0;
      #1 chk("route_out", {8'h00, r[7:0]}, {8'h00, route[g*8+:8]});
      chk("alt_out", e, alt[g*16+:16]);
      rd(12'(8 * g), v);
      chk("route_reg", {8'h00, r[7:0]}, v);
      rd(12'(8 * g + 4), v);
      chk("alt_reg", a, v);
    end
    $display("test routing done");
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      a = rnd();
      wclk(r, a[0]);
    end
    wclk(16'hfe02, 1'b1);
    rd(12'h200, v);
    chk("unmapped", 16'h0000, v);
    $display("test clock control done");
    for (int c = 0; c < 4; c++) begin
      wclk(16'(c << 2), 1'b1);
      for (int k = 0; k < 6; k++) begin
        r = rnd();
        @(posedge mclk);
        g0 <= (k < 2) ? 4'h0 : r[3:0];
        repeat (2) @(posedge mclk);
        e = (c == 0) ? 16'h0000 : {15'h0000, ((g0 & ((4'h1 << (c + 1)) - 4'h1)) == 4'h0)};
        #1 chk("key_reset", e, {15'h0000, krst});
      end
    end
    $display("test key reset done");
    for (int m = 0; m < 3; m++) begin
      for (int n = 0; n < 5; n++) begin
        @(posedge mclk);
        dbg <= (m > 0);
        wclk(16'((m == 2) << 8 | n << 4 | (n % 2 ? 1 : 3)), 1'b1);
        #1 chk("clk_run", {15'h0000, (m != 1)}, {15'h0000, crun});
        cnt = 0;
        for (int i = 0; i < 20; i++) begin
          r = rnd();
          @(posedge mclk);
          tick <= (i < 16) ? ((n % 2) ? {r[3:2], 1'b1, r[0]} : {1'b1, r[2:0]}) : 4'h0;
          #1 cnt += stick;
        end
        chk("ticks", 16'((m == 1) ? 0 : 16 >> n), 16'(cnt));
      end
    end
    $display("test sample clock done");
    wr(12'h104, 16'hffff);
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 7; j++) begin
        fr[j*16+:16] = (k == 0) ? 16'hffff : (k == 3) ? 16'h0000 : rnd();
        er[j*16+:16] = (k == 0) ? 16'h0000 : rnd();
      end
      if (k == 1) begin
        fr[0] = 1'b1;
        er[0] = 1'b1;
      end
      @(posedge mclk);
      flg <= fr[103:0];
      ena <= er[103:0];
      repeat (2) @(posedge mclk);
      e = 16'h0000;
      for (int g = 0; g < 8; g++) e[g] = |(fr[g*8+:8] & er[g*8+:8]);
      wr(12'h104, 16'h0000);
      rd(12'h104, v);
      chk("summary", e, v);
    end
    $display("test summary done");
    wrap_up();
  end
endmodule : pfc_top_tb_top
`default_nettype wire
